// ==== core/fbl_map.vh ====
/*
  Constants for the flash boot select and serial loader: code map,
  boot defaults, record layout, serial characters.
  Assumes it is included by bare name in every design file.
*/
`ifndef FBL_MAP_VH
`define FBL_MAP_VH

// ==========================================================
// code map
`define FBL_USER_START 16'h0000
`define FBL_BOOT_BASE 16'hfc00
`define FBL_BOOT_TOP 16'hffff
`define FBL_BOOT_LOW 8'h00
`define FBL_PAGE_LOW 7'h00
`define FBL_PAGE_HIGH 7'h7f
`define FBL_ERASED 8'hff

// ==========================================================
// non-volatile boot elements, erase defaults, security default also loaded at reset
`define FBL_BOOT_VEC_DEF 8'hfc
`define FBL_BOOT_STAT_DEF 1'b1
`define FBL_SEC_DEF 3'h0

// ==========================================================
// records
`define FBL_MAX_DATA 8'h20
`define FBL_HDR_BYTES 8'h05
`define FBL_REC_DATA 8'h00
`define FBL_REC_EOF 8'h01

// ==========================================================
// serial characters
`define FBL_CH_U 8'h55
`define FBL_CH_COLON 8'h3a
`define FBL_CH_CR 8'h0d
`define FBL_CH_LF 8'h0a
`define FBL_CH_X 8'h58
`define FBL_CH_DOT 8'h2e

// ==========================================================
// timing
`define FBL_BAUD_W 18
`define FBL_STRAP_WAIT 2'h3

`endif

// ==== core/fbl_flash.v ====
/*
  Program flash array with byte read, byte write, 128-byte page erase,
  chip erase, boot status, boot vector and security bits.
  Assumes requests arrive on mclk; requests during busy are ignored.
*/
`default_nettype none
`include "fbl_map.vh"

module fbl_flash (
  input wire mclk,
  input wire arst_n,
  input wire [15:0] rd_addr,
  output reg [7:0] rd_data,
  input wire wr_en,
  input wire [15:0] wr_addr,
  input wire [7:0] wr_data,
  input wire page_erase,
  input wire [8:0] page_sel,
  input wire chip_erase,
  input wire status_wr,
  input wire vector_wr,
  input wire [7:0] nv_data,
  input wire [2:0] sec_set,
  output reg busy,
  output reg boot_status = `FBL_BOOT_STAT_DEF,
  output reg [7:0] boot_vector = `FBL_BOOT_VEC_DEF,
  output reg [2:0] security
);

reg [7:0] mem [0:65535];
reg [15:0] er_ptr;
reg [15:0] er_end;
wire mem_we = busy ? 1'b1 : (wr_en & ~page_erase & ~chip_erase);
wire [15:0] mem_wa = busy ? er_ptr : wr_addr;
wire [7:0] mem_wd = busy ? `FBL_ERASED : wr_data;

// ==========================================================
// array port, one byte per cycle
always @(posedge mclk)
begin
  rd_data <= mem[rd_addr];
  if (mem_we)
    mem[mem_wa] <= mem_wd;
end

// ==========================================================
// erase sequencer and boot elements
always @(posedge mclk or negedge arst_n)
begin
  if (!arst_n)
  begin
    busy <= 1'b0;
    er_ptr <= `FBL_USER_START;
    er_end <= `FBL_USER_START;
    // boot status and boot vector are not reset; security bits are
    security <= `FBL_SEC_DEF;
  end
  else if (busy)
  begin
    if (er_ptr == er_end)
      busy <= 1'b0;
    else
      er_ptr <= er_ptr + 16'h0001;
  end
  else if (chip_erase)
  begin
    busy <= 1'b1;
    er_ptr <= `FBL_USER_START;
    er_end <= `FBL_BOOT_TOP;
    security <= `FBL_SEC_DEF;
    boot_vector <= `FBL_BOOT_VEC_DEF;
    boot_status <= `FBL_BOOT_STAT_DEF;
  end
  else if (page_erase)
  begin
    busy <= 1'b1;
    er_ptr <= {page_sel, `FBL_PAGE_LOW};
    er_end <= {page_sel, `FBL_PAGE_HIGH};
  end
  else
  begin
    security <= security | sec_set;
    if (status_wr)
      boot_status <= nv_data[0];
    if (vector_wr)
      boot_vector <= nv_data;
  end
end

endmodule // fbl_flash

`default_nettype wire

// ==== core/fbl_tx.v ====
/*
  Serial transmitter, 8 data bits, one start and one stop bit,
  bit length in mclk cycles given by the measured bit time.
  Assumes go is a one-cycle pulse raised only while busy is low.
*/
`default_nettype none
`include "fbl_map.vh"

module fbl_tx (
  input wire mclk,
  input wire arst_n,
  input wire [`FBL_BAUD_W-1:0] bit_cycles,
  input wire go,
  input wire [7:0] data,
  output reg txd,
  output reg busy
);

reg [8:0] sh;
reg [3:0] left;
reg [`FBL_BAUD_W-1:0] cnt;
wire [`FBL_BAUD_W-1:0] bc_m1 = bit_cycles - 1'b1;

always @(posedge mclk or negedge arst_n)
begin
  if (!arst_n)
  begin
    txd <= 1'b1;
    busy <= 1'b0;
    sh <= 9'h1ff;
    left <= 4'h0;
    cnt <= {`FBL_BAUD_W{1'b0}};
  end
  else if (!busy)
  begin
    if (go)
    begin
      txd <= 1'b0;
      sh <= {1'b1, data};
      left <= 4'h9;
      cnt <= {`FBL_BAUD_W{1'b0}};
      busy <= 1'b1;
    end
  end
  else if (cnt == bc_m1)
  begin
    cnt <= {`FBL_BAUD_W{1'b0}};
    if (left == 4'h0)
      busy <= 1'b0;
    else
    begin
      txd <= sh[0];
      sh <= {1'b1, sh[8:1]};
      left <= left - 4'h1;
    end
  end
  else
    cnt <= cnt + 1'b1;
end

endmodule // fbl_tx

`default_nettype wire

// ==== core/fbl_loader.v ====
/*
  Boot source selection, boot block overlay and serial record loader
  with automatic baud detection, echo and record acknowledgement.
  Assumes one clock mclk at 50 MHz, asynchronous active-low reset,
  an external combinational boot block ROM addressed by boot_rom_addr.
*/
`default_nettype none
`include "fbl_map.vh"

// What this block does
// - flash reads and writes single bytes and erases 128-byte pages
// - chip erase clears all user code and the security bits
// - enabled boot block replaces code reads at FC00H to FFFFH
// - boot block can be switched off at run time
// - after reset, boot status zero with fetch strobe high starts execution at 0000H
// - nonzero boot status starts at boot vector high byte, 00H low
// - boot vector defaults to FCH, pointing at the loader
// - forced loader entry at power-on takes the boot vector path
// - baud count comes from measuring one received bit in clocks
// - every received character is echoed back
// - after baud set, only colon-led hex records ending CR LF count
// - record holds count, address, type, data, checksum as hex pairs
// - at most 32 data bytes in a record
// - type 00 programs data bytes from the record address
// - type 01 is end of file, no flash work
// - record is buffered and its checksum summed on arrival
// - requested operation waits until the whole record is in
// - bad checksum answers X and skips the operation
// - good checksum with valid count and length answers a period
// - fetch strobe low at reset release starts at the boot vector
module fbl_loader (
  input wire mclk,
  input wire arst_n,
  input wire rxd,
  output wire txd,
  input wire program_fetch_strobe_n,
  input wire boot_block_disable,
  input wire fetch_req,
  input wire [15:0] fetch_addr,
  output reg [7:0] fetch_data,
  output reg fetch_valid,
  output reg [9:0] boot_rom_addr,
  input wire [7:0] boot_rom_data,
  output reg [15:0] start_addr,
  output reg start_valid,
  output reg serial_loader_mode,
  input wire app_page_erase,
  input wire [8:0] app_page_sel,
  input wire app_chip_erase,
  input wire app_status_wr,
  input wire app_vector_wr,
  input wire [7:0] app_nv_data,
  input wire [2:0] app_security_set,
  output wire flash_busy,
  output wire [2:0] security_bits,
  output reg rec_ok,
  output reg rec_bad
);

// ==========================================================
// functions
function [4:0] hex_val;
  input [7:0] c;
  begin
    if (c >= 8'h30 && c <= 8'h39)
      hex_val = {1'b1, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      hex_val = {1'b1, c[3:0] + 4'h9};
    else
      hex_val = 5'h00;
  end
endfunction

// ==========================================================
// pin synchronisers
reg rx_s1;
reg rx_s2;
reg pfs_s1;
reg pfs_s2;

always @(posedge mclk or negedge arst_n)
begin
  if (!arst_n)
  begin
    rx_s1 <= 1'b1;
    rx_s2 <= 1'b1;
    pfs_s1 <= 1'b1;
    pfs_s2 <= 1'b1;
  end
  else
  begin
    rx_s1 <= rxd;
    rx_s2 <= rx_s1;
    pfs_s1 <= program_fetch_strobe_n;
    pfs_s2 <= pfs_s1;
  end
end

// ==========================================================
// flash array
reg fl_wr_en;
reg [15:0] fl_wr_addr;
reg [7:0] fl_wr_data;
wire [7:0] fl_rd_data;
wire boot_status;
wire [7:0] boot_vector;

fbl_flash u_flash (
  .mclk(mclk),
  .arst_n(arst_n),
  .rd_addr(fetch_addr),
  .rd_data(fl_rd_data),
  .wr_en(fl_wr_en),
  .wr_addr(fl_wr_addr),
  .wr_data(fl_wr_data),
  .page_erase(app_page_erase),
  .page_sel(app_page_sel),
  .chip_erase(app_chip_erase),
  .status_wr(app_status_wr),
  .vector_wr(app_vector_wr),
  .nv_data(app_nv_data),
  .sec_set(app_security_set),
  .busy(flash_busy),
  .boot_status(boot_status),
  .boot_vector(boot_vector),
  .security(security_bits)
);

// ==========================================================
// start address selection after reset
reg [1:0] strap_cnt;

always @(posedge mclk or negedge arst_n)
begin
  if (!arst_n)
  begin
    strap_cnt <= 2'h0;
    start_valid <= 1'b0;
    start_addr <= `FBL_USER_START;
    serial_loader_mode <= 1'b0;
  end
  else if (!start_valid)
  begin
    if (strap_cnt == `FBL_STRAP_WAIT)
    begin
      start_valid <= 1'b1;
      if (boot_status || !pfs_s2)
      begin
        start_addr <= {boot_vector, `FBL_BOOT_LOW};
        serial_loader_mode <= 1'b1;
      end
      else
        start_addr <= `FBL_USER_START;
    end
    else
      strap_cnt <= strap_cnt + 2'h1;
  end
end

// ==========================================================
// code fetch with boot block overlay, two cycles
reg f_pend;
reg f_boot;

always @(posedge mclk or negedge arst_n)
begin
  if (!arst_n)
  begin
    f_pend <= 1'b0;
    f_boot <= 1'b0;
    boot_rom_addr <= 10'h000;
    fetch_valid <= 1'b0;
    fetch_data <= 8'h00;
  end
  else
  begin
    f_pend <= fetch_req;
    f_boot <= fetch_req && !boot_block_disable && fetch_addr >= `FBL_BOOT_BASE;
    boot_rom_addr <= fetch_addr[9:0];
    fetch_valid <= f_pend;
    if (f_pend)
      fetch_data <= f_boot ? boot_rom_data : fl_rd_data;
  end
end

// ==========================================================
// receiver with bit time measurement
localparam R_WAIT = 3'h0;
localparam R_MEAS = 3'h1;
localparam R_SETTLE = 3'h2;
localparam R_IDLE = 3'h3;
localparam R_START = 3'h4;
localparam R_DATA = 3'h5;
localparam R_STOP = 3'h6;

reg [2:0] rx_st;
reg [`FBL_BAUD_W-1:0] rx_cnt;
reg [`FBL_BAUD_W-1:0] bit_cycles;
reg [2:0] bit_n;
reg [7:0] rx_sh;
reg rx_valid;
reg [7:0] rx_byte;
wire [`FBL_BAUD_W-1:0] half = {1'b0, bit_cycles[`FBL_BAUD_W-1:1]};
wire [`FBL_BAUD_W-1:0] bc_m1 = bit_cycles - 1'b1;
wire [`FBL_BAUD_W-1:0] bc_1p5 = bit_cycles + half;

always @(posedge mclk or negedge arst_n)
begin
  if (!arst_n)
  begin
    rx_st <= R_WAIT;
    rx_cnt <= {`FBL_BAUD_W{1'b0}};
    bit_cycles <= {`FBL_BAUD_W{1'b0}};
    bit_n <= 3'h0;
    rx_sh <= 8'h00;
    rx_valid <= 1'b0;
    rx_byte <= 8'h00;
  end
  else
  begin
    rx_valid <= 1'b0;
    case (rx_st)
      R_WAIT:
        if (!rx_s2)
        begin
          rx_cnt <= {{(`FBL_BAUD_W-1){1'b0}}, 1'b1};
          rx_st <= R_MEAS;
        end
      R_MEAS:
        if (rx_s2)
        begin
          bit_cycles <= rx_cnt;
          rx_cnt <= {`FBL_BAUD_W{1'b0}};
          rx_st <= R_SETTLE;
        end
        else
          rx_cnt <= rx_cnt + 1'b1;
      R_SETTLE:
        if (!rx_s2)
          rx_cnt <= {`FBL_BAUD_W{1'b0}};
        else if (rx_cnt == bc_1p5)
        begin
          rx_valid <= 1'b1;
          rx_byte <= `FBL_CH_U;
          rx_st <= R_IDLE;
        end
        else
          rx_cnt <= rx_cnt + 1'b1;
      R_IDLE:
        if (!rx_s2)
        begin
          rx_cnt <= {`FBL_BAUD_W{1'b0}};
          rx_st <= R_START;
        end
      R_START:
        if (rx_cnt == half)
        begin
          rx_cnt <= {`FBL_BAUD_W{1'b0}};
          bit_n <= 3'h0;
          rx_st <= rx_s2 ? R_IDLE : R_DATA;
        end
        else
          rx_cnt <= rx_cnt + 1'b1;
      R_DATA:
        if (rx_cnt == bc_m1)
        begin
          rx_cnt <= {`FBL_BAUD_W{1'b0}};
          rx_sh <= {rx_s2, rx_sh[7:1]};
          bit_n <= bit_n + 3'h1;
          if (bit_n == 3'h7)
            rx_st <= R_STOP;
        end
        else
          rx_cnt <= rx_cnt + 1'b1;
      R_STOP:
        if (rx_cnt == bc_m1)
        begin
          rx_cnt <= {`FBL_BAUD_W{1'b0}};
          rx_valid <= rx_s2;
          rx_byte <= rx_sh;
          rx_st <= R_IDLE;
        end
        else
          rx_cnt <= rx_cnt + 1'b1;
      default:
        rx_st <= R_WAIT;
    endcase
  end
end

// ==========================================================
// record parser
localparam P_BAUD = 2'h0;
localparam P_IDLE = 2'h1;
localparam P_HEX = 2'h2;
localparam P_LF = 2'h3;

reg [1:0] ps;
reg [7:0] rec_buf [0:31];
reg [3:0] hi_nib;
reg nib_odd;
reg [6:0] byte_idx;
reg [7:0] rec_cnt;
reg [15:0] rec_addr;
reg [7:0] rec_type;
reg [7:0] sum;
reg rec_err;
reg ack_set;
reg [7:0] ack_val;
reg prog_start;
wire [4:0] hv = hex_val(rx_byte);
wire [7:0] full_byte = {hi_nib, hv[3:0]};
wire [7:0] data_idx = {1'b0, byte_idx} - 8'h04;
wire [7:0] rec_len = rec_cnt + `FBL_HDR_BYTES;
wire sum_ok = (sum == 8'h00) && !rec_err;

always @(posedge mclk)
begin
  if (rx_valid && ps == P_HEX && hv[4] && nib_odd && byte_idx >= 7'h04 && data_idx < `FBL_MAX_DATA)
    rec_buf[data_idx[4:0]] <= full_byte;
end

always @(posedge mclk or negedge arst_n)
begin
  if (!arst_n)
  begin
    ps <= P_BAUD;
    hi_nib <= 4'h0;
    nib_odd <= 1'b0;
    byte_idx <= 7'h00;
    rec_cnt <= 8'h00;
    rec_addr <= 16'h0000;
    rec_type <= 8'h00;
    sum <= 8'h00;
    rec_err <= 1'b0;
    ack_set <= 1'b0;
    ack_val <= 8'h00;
    prog_start <= 1'b0;
    rec_ok <= 1'b0;
    rec_bad <= 1'b0;
  end
  else
  begin
    ack_set <= 1'b0;
    prog_start <= 1'b0;
    rec_ok <= 1'b0;
    rec_bad <= 1'b0;
    if (rx_valid)
      case (ps)
        P_BAUD:
          ps <= P_IDLE;
        P_IDLE:
          if (rx_byte == `FBL_CH_COLON)
          begin
            ps <= P_HEX;
            nib_odd <= 1'b0;
            byte_idx <= 7'h00;
            sum <= 8'h00;
            rec_err <= 1'b0;
          end
        P_HEX:
          if (rx_byte == `FBL_CH_CR)
          begin
            ps <= P_LF;
            if (nib_odd || {1'b0, byte_idx} != rec_len)
              rec_err <= 1'b1;
          end
          else if (!hv[4])
            ps <= P_IDLE;
          else if (!nib_odd)
          begin
            hi_nib <= hv[3:0];
            nib_odd <= 1'b1;
          end
          else
          begin
            nib_odd <= 1'b0;
            sum <= sum + full_byte;
            if (byte_idx != 7'h7f)
              byte_idx <= byte_idx + 7'h01;
            case (byte_idx)
              7'h00:
              begin
                rec_cnt <= full_byte;
                if (full_byte > `FBL_MAX_DATA)
                  rec_err <= 1'b1;
              end
              7'h01:
                rec_addr[15:8] <= full_byte;
              7'h02:
                rec_addr[7:0] <= full_byte;
              7'h03:
                rec_type <= full_byte;
              default:
                rec_type <= rec_type;
            endcase
          end
        P_LF:
        begin
          ps <= P_IDLE;
          if (rx_byte == `FBL_CH_LF)
          begin
            ack_set <= 1'b1;
            ack_val <= sum_ok ? `FBL_CH_DOT : `FBL_CH_X;
            rec_ok <= sum_ok;
            rec_bad <= !sum_ok;
            prog_start <= sum_ok && rec_type == `FBL_REC_DATA && rec_cnt != 8'h00;
          end
        end
        default:
          ps <= P_IDLE;
      endcase
  end
end

// ==========================================================
// programming of a data record, one byte per free cycle
reg prog_active;
reg [5:0] prog_idx;
wire prog_go = prog_active && !flash_busy && !app_page_erase && !app_chip_erase;

always @(posedge mclk or negedge arst_n)
begin
  if (!arst_n)
  begin
    prog_active <= 1'b0;
    prog_idx <= 6'h00;
    fl_wr_en <= 1'b0;
    fl_wr_addr <= 16'h0000;
    fl_wr_data <= 8'h00;
  end
  else
  begin
    fl_wr_en <= prog_go;
    if (prog_start)
    begin
      prog_active <= 1'b1;
      prog_idx <= 6'h00;
    end
    else if (prog_go)
    begin
      fl_wr_addr <= rec_addr + {10'h000, prog_idx};
      fl_wr_data <= rec_buf[prog_idx[4:0]];
      prog_idx <= prog_idx + 6'h01;
      if ({2'b00, prog_idx} == rec_cnt - 8'h01)
        prog_active <= 1'b0;
    end
  end
end

// ==========================================================
// echo and answer transmission
reg echo_pend;
reg [7:0] echo_val;
reg ack_pend;
reg [7:0] ack_hold;
reg tx_go;
reg [7:0] tx_char;
wire tx_busy;

always @(posedge mclk or negedge arst_n)
begin
  if (!arst_n)
  begin
    echo_pend <= 1'b0;
    echo_val <= 8'h00;
    ack_pend <= 1'b0;
    ack_hold <= 8'h00;
    tx_go <= 1'b0;
    tx_char <= 8'h00;
  end
  else
  begin
    tx_go <= 1'b0;
    if (!tx_busy && !tx_go && echo_pend)
    begin
      tx_go <= 1'b1;
      tx_char <= echo_val;
      echo_pend <= 1'b0;
    end
    else if (!tx_busy && !tx_go && ack_pend)
    begin
      tx_go <= 1'b1;
      tx_char <= ack_hold;
      ack_pend <= 1'b0;
    end
    if (rx_valid)
    begin
      echo_pend <= 1'b1;
      echo_val <= rx_byte;
    end
    if (ack_set)
    begin
      ack_pend <= 1'b1;
      ack_hold <= ack_val;
    end
  end
end

fbl_tx u_tx (
  .mclk(mclk),
  .arst_n(arst_n),
  .bit_cycles(bit_cycles),
  .go(tx_go),
  .data(tx_char),
  .txd(txd),
  .busy(tx_busy)
);

endmodule // fbl_loader

`default_nettype wire

// ==== test/fbl_loader_props.sv ====
/*
  Concurrent checks on the ports of fbl_loader.
  Assumes one clock mclk and the asynchronous active-low reset arst_n.
*/
`default_nettype none
module fbl_loader_props (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] fetch_data,
  input wire logic fetch_valid,
  input wire logic [9:0] boot_rom_addr,
  input wire logic [7:0] boot_rom_data,
  input wire logic boot_block_disable,
  input wire logic [15:0] start_addr,
  input wire logic start_valid,
  input wire logic serial_loader_mode,
  input wire logic program_fetch_strobe_n,
  input wire logic app_page_erase,
  input wire logic app_chip_erase,
  input wire logic flash_busy,
  input wire logic [2:0] security_bits,
  input wire logic rec_ok,
  input wire logic rec_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rel_cnt;
  logic [1:0] chip_st;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // cycles since release, chip erase progress
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rel_cnt <= 3'h0;
      chip_st <= 2'h0;
    end
    else
    begin
      if (rel_cnt != 3'h7)
        rel_cnt <= rel_cnt + 3'h1;
      if (chip_st == 2'h0 && app_chip_erase && !flash_busy)
        chip_st <= 2'h1;
      else if (chip_st == 2'h1 && flash_busy)
        chip_st <= 2'h2;
      else if (chip_st == 2'h2 && !flash_busy)
        chip_st <= 2'h0;
    end
  end
  // ==========================================================
  // properties
  property p_fetch_lat;
    fetch_req |-> ##2 fetch_valid;
  endproperty
  a_fetch_lat: assert property (p_fetch_lat) else $error("fetch answer late");
  property p_rom_addr;
    fetch_req |-> ##1 ({6'h00, boot_rom_addr} == ($past(fetch_addr) & 16'h03ff));
  endproperty
  a_rom_addr: assert property (p_rom_addr) else $error("boot rom address wrong");
  property p_overlay;
    fetch_req && fetch_addr >= 16'hfc00 && !boot_block_disable |-> ##2 fetch_data == $past(boot_rom_data);
  endproperty
  a_overlay: assert property (p_overlay) else $error("boot block not overlaid");
  property p_start_time;
    start_valid == (rel_cnt >= 3'h4);
  endproperty
  a_start_time: assert property (p_start_time) else $error("start valid at wrong edge");
  property p_start_user;
    start_valid && !serial_loader_mode |-> start_addr == 16'h0000;
  endproperty
  a_start_user: assert property (p_start_user) else $error("user start not zero");
  property p_start_boot;
    start_valid && serial_loader_mode |-> start_addr[7:0] == 8'h00;
  endproperty
  a_start_boot: assert property (p_start_boot) else $error("boot start low byte not zero");
  property p_strap;
    $rose(start_valid) && !program_fetch_strobe_n |-> serial_loader_mode;
  endproperty
  a_strap: assert property (p_strap) else $error("strap did not force loader");
  property p_rec_pulse;
    (rec_ok || rec_bad) |-> !(rec_ok && rec_bad) ##1 (!rec_ok && !rec_bad);
  endproperty
  a_rec_pulse: assert property (p_rec_pulse) else $error("record verdict pulse wrong");
  property p_erase_busy;
    app_page_erase && !flash_busy |-> ##[1:2] flash_busy [*8];
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("page erase not busy");
  property p_chip_clr;
    chip_st == 2'h2 && !flash_busy |-> security_bits == 3'h0;
  endproperty
  a_chip_clr: assert property (p_chip_clr) else $error("chip erase left security");
  c_ok: cover property (rec_ok);
  c_bad: cover property (rec_bad);
  c_busy: cover property ($fell(flash_busy));
endmodule // fbl_loader_props

bind fbl_loader fbl_loader_props u_props (.mclk(mclk), .arst_n(arst_n), .fetch_req(fetch_req),
  .fetch_addr(fetch_addr), .fetch_data(fetch_data), .fetch_valid(fetch_valid), .boot_rom_addr(boot_rom_addr),
  .boot_rom_data(boot_rom_data), .boot_block_disable(boot_block_disable), .start_addr(start_addr),
  .start_valid(start_valid), .serial_loader_mode(serial_loader_mode),
  .program_fetch_strobe_n(program_fetch_strobe_n), .app_page_erase(app_page_erase),
  .app_chip_erase(app_chip_erase), .flash_busy(flash_busy), .security_bits(security_bits),
  .rec_ok(rec_ok), .rec_bad(rec_bad));
`default_nettype wire

// ==== test/fbl_host.sv ====
/*
  Host programming tool on the serial link: sends frames, collects replies.
  Assumes 8 data bits, one start and one stop bit of BIT mclk cycles, idle high.
*/
`default_nettype none
module fbl_host #(parameter int BIT = 12) (
  input wire logic mclk,
  output var logic rxd,
  input wire logic txd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial rxd = 1'b1;
  task automatic put(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk) rxd <= f[i];
      repeat (BIT - 1) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
  endtask
  // sample each reply bit mid-way
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge mclk);
      sh[i] = txd;
    end
    rx_q.push_back(sh);
    repeat (BIT) @(posedge mclk);
  end
endmodule // fbl_host
`default_nettype wire

// ==== test/fbl_loader_tb.sv ====
/*
  Self-checking bench for fbl_loader: start address, serial records, overlay, erase.
  Assumes fbl_host on the serial pins and a synthetic boot block ROM.
*/
`default_nettype none
module fbl_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 12;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic pfs_n = 1'b1, bbd = 1'b0, fetch_req = 1'b0, pg_er = 1'b0, ch_er = 1'b0, st_wr = 1'b0, vec_wr = 1'b0;
  logic [15:0] fetch_addr = 16'h0000;
  logic [8:0] pg_sel = 9'h000;
  logic [2:0] sec_set = 3'h0;
  logic [7:0] nv_d = 8'h00;
  wire logic rxd, txd, fetch_valid, start_valid, slm, busy, rec_ok, rec_bad;
  wire logic [7:0] fetch_data;
  wire logic [9:0] rom_a;
  wire logic [15:0] start_addr;
  wire logic [2:0] sec;
  wire logic [7:0] rom_d = rom_a[7:0] ^ 8'h5a;
  int n_mismatch = 0, samples_checked = 0, n_ok = 0, n_bad = 0;
  always #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (rec_ok === 1'b1)
      n_ok++;
    if (rec_bad === 1'b1)
      n_bad++;
  end
  fbl_loader uut (.mclk(mclk), .arst_n(arst_n), .rxd(rxd), .txd(txd), .program_fetch_strobe_n(pfs_n),
    .boot_block_disable(bbd), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
    .fetch_valid(fetch_valid), .boot_rom_addr(rom_a), .boot_rom_data(rom_d), .start_addr(start_addr),
    .start_valid(start_valid), .serial_loader_mode(slm), .app_page_erase(pg_er), .app_page_sel(pg_sel),
    .app_chip_erase(ch_er), .app_status_wr(st_wr), .app_vector_wr(vec_wr), .app_nv_data(nv_d),
    .app_security_set(sec_set), .flash_busy(busy), .security_bits(sec), .rec_ok(rec_ok), .rec_bad(rec_bad));
  fbl_host #(.BIT(BIT)) host (.mclk(mclk), .rxd(rxd), .txd(txd));
  // ==========================================================
  // shared tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp_v);
    samples_checked++;
    if (got !== exp_v)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp_v);
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction
  task automatic do_reset(input logic strap);
    arst_n <= 1'b0;
    pfs_n <= strap;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
  task automatic fetch(input logic [15:0] a, input logic [7:0] e);
    int k;
    @(posedge mclk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge mclk);
    fetch_req <= 1'b0;
    for (k = 0; k < 5 && fetch_valid !== 1'b1; k++)
      @(posedge mclk) #1;
    cmp(fetch_valid, 1'b1);
    cmp(fetch_data, e);
  endtask
  task automatic wait_rx(input int n);
    int k;
    for (k = 0; k < 60 * BIT && host.rx_q.size() < n; k++)
      @(posedge mclk);
    if (k == 60 * BIT)
    begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic wait_idle(input int n);
    int k;
    repeat (3) @(posedge mclk);
    for (k = 0; k < n && busy !== 1'b0; k++)
      @(posedge mclk);
    cmp(busy, 1'b0);
  endtask
  task automatic send_rec(input logic [7:0] b[$], input logic bad, input logic ok);
    logic [7:0] s;
    logic [7:0] e[$];
    int o, ob;
    s = 8'h00;
    foreach (b[i]) s += b[i];
    b.push_back((8'h00 - s) ^ {7'h00, bad});
    e.push_back(8'h3a);
    foreach (b[i])
    begin
      e.push_back(hx(b[i][7:4]));
      e.push_back(hx(b[i][3:0]));
    end
    e.push_back(8'h0d);
    e.push_back(8'h0a);
    host.rx_q.delete();
    o = n_ok;
    ob = n_bad;
    foreach (e[i]) host.put(e[i]);
    e.push_back(ok ? 8'h2e : 8'h58);
    wait_rx(e.size());
    foreach (e[i]) cmp(host.rx_q[i], e[i]);
    cmp(n_ok - o, ok);
    cmp(n_bad - ob, !ok);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_boot;
    do_reset(1'b1);
    cmp(start_valid, 1'b1);
    cmp(start_addr, 16'hfc00);
    cmp(slm, 1'b1);
    nv_d <= 8'h12;
    {st_wr, vec_wr} <= 2'b11;
    @(posedge mclk);
    {st_wr, vec_wr} <= 2'b00;
    do_reset(1'b1);
    cmp(start_addr, 16'h0000);
    cmp(slm, 1'b0);
    do_reset(1'b0);
    cmp(start_addr, 16'h1200);
    cmp(slm, 1'b1);
    $display("test boot done");
  endtask
  task automatic t_loader;
    logic [7:0] q[$];
    host.rx_q.delete();
    host.put(8'h55);
    wait_rx(1);
    cmp(host.rx_q[0], 8'h55);
    send_rec('{8'h03, 8'h01, 8'h00, 8'h00, 8'h11, 8'h22, 8'h33}, 1'b0, 1'b1);
    send_rec('{8'h02, 8'hfb, 8'hff, 8'h00, 8'ha5, 8'h3c}, 1'b0, 1'b1);
    q = '{8'h20, 8'h02, 8'h00, 8'h00};
    for (int i = 0; i < 32; i++) q.push_back(8'(i));
    send_rec(q, 1'b0, 1'b1);
    q = '{8'h21, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 33; i++) q.push_back(8'h77);
    send_rec(q, 1'b0, 1'b0);
    send_rec('{8'h02, 8'h01, 8'h00, 8'h00, 8'hde, 8'had}, 1'b1, 1'b0);
    send_rec('{8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b1);
    fetch(16'h0100, 8'h11);
    fetch(16'h0102, 8'h33);
    fetch(16'h0200, 8'h00);
    fetch(16'h021f, 8'h1f);
    $display("test loader done");
  endtask
  task automatic t_overlay;
    fetch(16'hfbff, 8'ha5);
    fetch(16'hfc00, 8'h00 ^ 8'h5a);
    fetch(16'hffff, 8'hff ^ 8'h5a);
    bbd <= 1'b1;
    fetch(16'hfc00, 8'h3c);
    bbd <= 1'b0;
    $display("test overlay done");
  endtask
  task automatic t_erase;
    @(posedge mclk);
    pg_sel <= 9'h002;
    pg_er <= 1'b1;
    @(posedge mclk);
    pg_er <= 1'b0;
    wait_idle(400);
    fetch(16'h0100, 8'hff);
    fetch(16'h0200, 8'h00);
    sec_set <= 3'h5;
    @(posedge mclk);
    sec_set <= 3'h0;
    repeat (3) @(posedge mclk);
    cmp(sec, 3'h5);
    ch_er <= 1'b1;
    @(posedge mclk);
    ch_er <= 1'b0;
    wait_idle(70000);
    cmp(sec, 3'h0);
    fetch(16'h0200, 8'hff);
    $display("test erase done");
  endtask
  initial
  begin
    t_boot();
    t_loader();
    t_overlay();
    t_erase();
    final_report();
  end
endmodule // fbl_loader_tb
`default_nettype wire
